// [burst_sram_pkg.sv]
package burst_sram_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DATA_W_DEF = 18;
	localparam int ADDR_W_DEF = 21;
	localparam int LANES_DEF = 2;
	localparam int BURST_WORDS = 2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int DLL_STOP_PS = 30000;
	localparam int DLL_STOP_CYCLES =
		(DLL_STOP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DLL_LOCK_CYCLES = 1024;
	localparam int IMP_UPDATE_CYCLES = 1024;
	// ----------------------------------------
	// controller register map
	// ----------------------------------------
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_ADDR = 6'h04;
	localparam logic [5:0] REG_WDATA0 = 6'h08;
	localparam logic [5:0] REG_WDATA1 = 6'h0c;
	localparam logic [5:0] REG_LANES = 6'h10;
	localparam logic [5:0] REG_CMD = 6'h14;
	localparam logic [5:0] REG_STATUS = 6'h18;
	localparam logic [5:0] REG_RDATA0 = 6'h1c;
	localparam logic [5:0] REG_RDATA1 = 6'h20;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_LOOP_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h2;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam logic [31:0] LANES_RESET = 32'h0;
endpackage

// [burst_sram_if.sv]
`timescale 1ns/10ps
interface burst_sram_if
	import burst_sram_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF,
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int LANES = LANES_DEF
);
	logic k;
	logic k_n;
	logic c;
	logic c_n;
	logic [ADDR_W-1:0] addr;
	logic read_port_select_n;
	logic write_port_select_n;
	logic [LANES-1:0] byte_lane_select_n;
	logic [DATA_W-1:0] d;
	logic [DATA_W-1:0] q;
	logic q_oe;
	logic echo_timing;
	logic echo_timing_n;
	logic loop_disable_n;

	modport mem (
		input k, k_n, c, c_n, addr, read_port_select_n,
		input write_port_select_n, byte_lane_select_n, d, loop_disable_n,
		output q, q_oe, echo_timing, echo_timing_n
	);
	modport ctl (
		output k, k_n, c, c_n, addr, read_port_select_n,
		output write_port_select_n, byte_lane_select_n, d, loop_disable_n,
		input q, q_oe, echo_timing, echo_timing_n
	);
endinterface

// [lane_merge.sv]
`timescale 1ns/10ps
module lane_merge #(
	parameter int DATA_W = 18,
	parameter int LANES = 2
) (
	// words and lane selects
	input wire logic [DATA_W-1:0] old_i,
	input wire logic [DATA_W-1:0] new_i,
	input wire logic [LANES-1:0] sel_n_i,
	// result
	output logic [DATA_W-1:0] merged_o
);
	localparam int LANE_W = DATA_W / LANES;

	if (DATA_W % LANES != 0) begin : g_bad
		$error("lane_merge: DATA_W must divide into LANES");
	end

	// low select writes the lane, high keeps the old contents
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		assign merged_o[l*LANE_W +: LANE_W] = sel_n_i[l] ?
			old_i[l*LANE_W +: LANE_W] : new_i[l*LANE_W +: LANE_W];
	end
endmodule

// [burst_sram_device.sv]
`timescale 1ns/10ps
// Overview of operation
// - write: select low, words on both rises
// - read words on output clock rises t+1.5, t+2
// - burst address is latched address then plus one
// - inputs on input rises, outputs on output rises
// - selects sampled at true rise; both high is nop
// - deselect leaves other port, pending finishes
// - reset: ports deselected, outputs disabled
// - reads and writes independent, same cycle allowed
// - reads return newest data, forwarding pending write
// - lane selects sampled with each word
// - two lanes split word halves; both high none
// - unselected lane keeps stored contents
// - single clock: input clocks drive outputs
// - controller straps single clock by high outputs
// - two free-running echo clocks follow output clock
// - loop locks after fixed stable clock count
// - stopping input clocks resets the loop
// - loop disable low bypasses the loop
// - stopped clocks hold state, park clocks cleanly
// - outputs disabled after next output rise
module burst_sram_device
	import burst_sram_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF,
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int LANES = LANES_DEF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link to the controller
	burst_sram_if.mem link,
	// status
	output logic single_clock_o,
	output logic dll_locked_o,
	output logic impedance_update_o
);
	localparam int MEM_WORDS = BURST_WORDS << ADDR_W;

	if (DATA_W % LANES != 0 || ADDR_W < 1 || ADDR_W > 24) begin : g_bad
		$error("burst_sram_device: unsupported DATA_W, LANES or ADDR_W");
	end

	// ----------------------------------------
	// strap and clock edges
	// ----------------------------------------
	logic strap_armed_reg;
	logic single_reg;
	logic k_last_reg;
	logic kn_last_reg;
	logic oc_last_reg;
	logic ocn_last_reg;
	logic oclk;
	logic oclk_n;
	logic k_rise;
	logic kn_rise;
	logic oc_rise;
	logic ocn_rise;

	// strap caught once, at the first edge after reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_armed_reg <= 1'b1;
			single_reg <= 1'b0;
		end else if (strap_armed_reg) begin
			strap_armed_reg <= 1'b0;
			single_reg <= link.c & link.c_n;
		end
	end

	// single clock: input pair takes the output role
	assign oclk = single_reg ? link.k : link.c;
	assign oclk_n = single_reg ? link.k_n : link.c_n;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			k_last_reg <= 1'b0;
			kn_last_reg <= 1'b0;
			oc_last_reg <= 1'b0;
			ocn_last_reg <= 1'b0;
		end else begin
			k_last_reg <= link.k;
			kn_last_reg <= link.k_n;
			oc_last_reg <= oclk;
			ocn_last_reg <= oclk_n;
		end
	end

	// stopped clocks give no rises, so write and read port state holds
	assign k_rise = link.k & ~k_last_reg;
	assign kn_rise = link.k_n & ~kn_last_reg;
	assign oc_rise = oclk & ~oc_last_reg;
	assign ocn_rise = oclk_n & ~ocn_last_reg;
	assign single_clock_o = single_reg;

	// ----------------------------------------
	// array and write port
	// ----------------------------------------
	logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
	logic w_open_reg;
	logic [ADDR_W-1:0] w_addr_reg;
	logic [DATA_W-1:0] w_d0_reg;
	logic [LANES-1:0] w_s0_reg;
	logic c_pend_reg;
	logic [ADDR_W-1:0] c_addr_reg;
	logic [DATA_W-1:0] c_d_reg [BURST_WORDS];
	logic [LANES-1:0] c_s_reg [BURST_WORDS];
	logic [DATA_W-1:0] commit_word [BURST_WORDS];

	// first word with the start, select sampled at true rise only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w_open_reg <= 1'b0;
			w_addr_reg <= '0;
			w_d0_reg <= '0;
			w_s0_reg <= '1;
		end else if (k_rise) begin
			w_open_reg <= ~link.write_port_select_n;
			if (!link.write_port_select_n) begin
				w_addr_reg <= link.addr;
				w_d0_reg <= link.d;
				w_s0_reg <= link.byte_lane_select_n;
			end
		end else if (kn_rise) begin
			w_open_reg <= 1'b0;
		end
	end

	// second word on the complementary rise, whole burst handed on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c_pend_reg <= 1'b0;
			c_addr_reg <= '0;
			for (int i = 0; i < BURST_WORDS; i++) begin
				c_d_reg[i] <= '0;
				c_s_reg[i] <= '1;
			end
		end else begin
			c_pend_reg <= kn_rise & w_open_reg;
			if (kn_rise && w_open_reg) begin
				c_addr_reg <= w_addr_reg;
				c_d_reg[0] <= w_d0_reg;
				c_s_reg[0] <= w_s0_reg;
				c_d_reg[1] <= link.d;
				c_s_reg[1] <= link.byte_lane_select_n;
			end
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	logic r_pend_reg;
	logic [ADDR_W-1:0] r_addr_reg;
	logic arm_reg;
	logic second_reg;
	logic [DATA_W-1:0] q_w_reg [BURST_WORDS];
	logic [DATA_W-1:0] fwd_word [BURST_WORDS];
	logic [DATA_W-1:0] fetch_word [BURST_WORDS];
	logic fwd_hit;

	assign fwd_hit = c_pend_reg && (c_addr_reg == r_addr_reg);

	for (genvar i = 0; i < BURST_WORDS; i++) begin : g_word
		// burst word i sits at latched address plus i
		lane_merge #(
			.DATA_W(DATA_W),
			.LANES(LANES)
		) u_commit (
			.old_i(mem[{c_addr_reg, 1'(i)}]),
			.new_i(c_d_reg[i]),
			.sel_n_i(c_s_reg[i]),
			.merged_o(commit_word[i])
		);
		lane_merge #(
			.DATA_W(DATA_W),
			.LANES(LANES)
		) u_forward (
			.old_i(mem[{r_addr_reg, 1'(i)}]),
			.new_i(c_d_reg[i]),
			.sel_n_i(c_s_reg[i]),
			.merged_o(fwd_word[i])
		);
		assign fetch_word[i] = fwd_hit ?
			fwd_word[i] : mem[{r_addr_reg, 1'(i)}];
	end

	// commit lands at the same edge that a fetch may read
	always_ff @(posedge clk_i) begin
		if (c_pend_reg) begin
			for (int i = 0; i < BURST_WORDS; i++) begin
				mem[{c_addr_reg, 1'(i)}] <= commit_word[i];
			end
		end
	end

	// read latched at t, fetched at t+1 true rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_pend_reg <= 1'b0;
			r_addr_reg <= '0;
			arm_reg <= 1'b0;
			for (int i = 0; i < BURST_WORDS; i++) begin
				q_w_reg[i] <= '0;
			end
		end else if (k_rise) begin
			r_pend_reg <= ~link.read_port_select_n;
			if (!link.read_port_select_n) begin
				r_addr_reg <= link.addr;
			end
			if (r_pend_reg) begin
				for (int i = 0; i < BURST_WORDS; i++) begin
					q_w_reg[i] <= fetch_word[i];
				end
			end
			arm_reg <= r_pend_reg;
		end else if (ocn_rise) begin
			arm_reg <= 1'b0;
		end
	end

	// word 0 on complementary output rise, word 1 on true rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.q <= '0;
			link.q_oe <= 1'b0;
			second_reg <= 1'b0;
		end else if (ocn_rise) begin
			if (arm_reg) begin
				link.q <= q_w_reg[0];
				link.q_oe <= 1'b1;
				second_reg <= 1'b1;
			end else if (!second_reg) begin
				link.q_oe <= 1'b0;
			end
		end else if (oc_rise && second_reg) begin
			link.q <= q_w_reg[1];
			second_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// echo clocks, loop lock, impedance
	// ----------------------------------------
	logic [$clog2(DLL_STOP_CYCLES+1)-1:0] stop_cnt_reg;
	logic [$clog2(DLL_LOCK_CYCLES+1)-1:0] lock_cnt_reg;
	logic [$clog2(IMP_UPDATE_CYCLES)-1:0] imp_cnt_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.echo_timing <= 1'b0;
			link.echo_timing_n <= 1'b0;
		end else begin
			link.echo_timing <= oclk;
			link.echo_timing_n <= oclk_n;
		end
	end

	// cycles since the last true input rise
	always_ff @(posedge clk_i) begin
		if (rst_i || k_rise) begin
			stop_cnt_reg <= '0;
		end else if (32'(stop_cnt_reg) < DLL_STOP_CYCLES) begin
			stop_cnt_reg <= stop_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !link.loop_disable_n) begin
			lock_cnt_reg <= '0;
		end else if (32'(stop_cnt_reg) >= DLL_STOP_CYCLES) begin
			lock_cnt_reg <= '0;
		end else if (k_rise && 32'(lock_cnt_reg) < DLL_LOCK_CYCLES) begin
			lock_cnt_reg <= lock_cnt_reg + 1'b1;
		end
	end

	assign dll_locked_o = (32'(lock_cnt_reg) == DLL_LOCK_CYCLES);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imp_cnt_reg <= '0;
			impedance_update_o <= 1'b0;
		end else begin
			imp_cnt_reg <= imp_cnt_reg + 1'b1;
			impedance_update_o <= (32'(imp_cnt_reg) == IMP_UPDATE_CYCLES - 1);
		end
	end
endmodule

// [burst_sram_ctrl.sv]
`timescale 1ns/10ps
module burst_sram_ctrl
	import burst_sram_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF,
	parameter int ADDR_W = ADDR_W_DEF,
	parameter int LANES = LANES_DEF,
	parameter bit SINGLE_CLOCK = 1'b0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [5:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// link to the memory
	burst_sram_if.ctl link
);
	if (DATA_W > 32 || ADDR_W > 32 || 2 * LANES > 32) begin : g_bad
		$error("burst_sram_ctrl: widths exceed register width");
	end

	function automatic logic [31:0] wmerge(input logic [31:0] old,
			input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = val[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [1:0] ctrl_reg;
	logic [31:0] addr_reg;
	logic [31:0] wdata0_reg;
	logic [31:0] wdata1_reg;
	logic [31:0] lanes_reg;
	logic [DATA_W-1:0] rdata0_reg;
	logic [DATA_W-1:0] rdata1_reg;
	logic pend_wr_reg;
	logic pend_rd_reg;
	logic second_reg;
	logic rd_wait_reg;
	logic got0_reg;
	logic done_reg;
	logic busy;
	logic wb_wr;
	logic start_wr;
	logic start_rd;
	logic run;
	logic issue;

	// write lands at the edge where the master sees ack high
	assign wb_wr = cyc_i & stb_i & we_i & ack_o;
	assign busy = pend_wr_reg | pend_rd_reg | second_reg | rd_wait_reg;
	assign start_wr = wb_wr && adr_i == REG_CMD && sel_i[0] &&
		dat_i[CMD_WRITE_BIT] && !busy;
	assign start_rd = wb_wr && adr_i == REG_CMD && sel_i[0] &&
		dat_i[CMD_READ_BIT] && !busy;
	assign run = ctrl_reg[CTRL_RUN_BIT];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RESET;
			addr_reg <= '0;
			wdata0_reg <= '0;
			wdata1_reg <= '0;
			lanes_reg <= LANES_RESET;
		end else if (wb_wr) begin
			case (adr_i)
				REG_CTRL: ctrl_reg <= 2'(wmerge(32'(ctrl_reg), dat_i, sel_i));
				REG_ADDR: addr_reg <= wmerge(addr_reg, dat_i, sel_i);
				REG_WDATA0: wdata0_reg <= wmerge(wdata0_reg, dat_i, sel_i);
				REG_WDATA1: wdata1_reg <= wmerge(wdata1_reg, dat_i, sel_i);
				REG_LANES: lanes_reg <= wmerge(lanes_reg, dat_i, sel_i);
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else begin
			case (adr_i)
				REG_CTRL: dat_o <= 32'(ctrl_reg);
				REG_ADDR: dat_o <= addr_reg;
				REG_WDATA0: dat_o <= wdata0_reg;
				REG_WDATA1: dat_o <= wdata1_reg;
				REG_LANES: dat_o <= lanes_reg;
				REG_STATUS: dat_o <= 32'({done_reg, busy});
				REG_RDATA0: dat_o <= 32'(rdata0_reg);
				REG_RDATA1: dat_o <= 32'(rdata1_reg);
				default: dat_o <= '0;
			endcase
		end
	end

	// ----------------------------------------
	// clock generation
	// ----------------------------------------
	// stopped: input pair parked low, output pair parked high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.k <= 1'b0;
			link.k_n <= 1'b0;
			link.c <= SINGLE_CLOCK;
			link.c_n <= SINGLE_CLOCK;
		end else begin
			link.k <= run & ~link.k;
			link.k_n <= run & link.k;
			link.c <= SINGLE_CLOCK | ~run | ~link.k;
			link.c_n <= SINGLE_CLOCK | ~run | link.k;
		end
	end

	assign link.loop_disable_n = ctrl_reg[CTRL_LOOP_EN_BIT];

	// ----------------------------------------
	// transfers
	// ----------------------------------------
	// next edge raises the true input clock
	assign issue = run && !link.k && (pend_wr_reg || pend_rd_reg);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_wr_reg <= 1'b0;
			pend_rd_reg <= 1'b0;
		end else begin
			pend_wr_reg <= start_wr | (pend_wr_reg & ~issue);
			pend_rd_reg <= start_rd | (pend_rd_reg & ~issue);
		end
	end

	// write and read may start on the same rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.write_port_select_n <= 1'b1;
			link.read_port_select_n <= 1'b1;
			link.addr <= '0;
			link.d <= '0;
			link.byte_lane_select_n <= '1;
			second_reg <= 1'b0;
		end else begin
			second_reg <= issue & pend_wr_reg;
			link.write_port_select_n <= ~(issue & pend_wr_reg);
			link.read_port_select_n <= ~(issue & pend_rd_reg);
			if (issue) begin
				link.addr <= addr_reg[ADDR_W-1:0];
				link.d <= wdata0_reg[DATA_W-1:0];
				link.byte_lane_select_n <= lanes_reg[LANES-1:0];
			end else if (second_reg) begin
				link.d <= wdata1_reg[DATA_W-1:0];
				link.byte_lane_select_n <= lanes_reg[2*LANES-1:LANES];
			end
		end
	end

	// first enabled output word is A+0, the next is A+1
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_wait_reg <= 1'b0;
			got0_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata0_reg <= '0;
			rdata1_reg <= '0;
		end else begin
			if (issue && pend_rd_reg) begin
				rd_wait_reg <= 1'b1;
				done_reg <= 1'b0;
			end else if (rd_wait_reg && link.q_oe) begin
				if (!got0_reg) begin
					rdata0_reg <= link.q;
					got0_reg <= 1'b1;
				end else begin
					rdata1_reg <= link.q;
					got0_reg <= 1'b0;
					rd_wait_reg <= 1'b0;
					done_reg <= 1'b1;
				end
			end
		end
	end
endmodule

// [split_port_ddr_burst_sram_monitor.sv]
`timescale 1ns/10ps
module split_port_ddr_burst_sram_monitor #(
	parameter int DATA_W = 18,
	parameter int ADDR_W = 21,
	parameter int LANES = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// link signals
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic c_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [LANES-1:0] byte_lane_select_n,
	input wire logic [DATA_W-1:0] d,
	input wire logic [DATA_W-1:0] q,
	input wire logic q_oe,
	input wire logic echo_timing,
	input wire logic echo_timing_n,
	input wire logic loop_disable_n
);
	// ----------------------------------------
	// read start detect
	// ----------------------------------------
	logic k_reg;
	logic rd_start;
	always_ff @(posedge clk_i) begin
		k_reg <= k;
	end
	assign rd_start = k & ~k_reg & ~read_port_select_n;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_read_oe;
		rd_start |-> ##4 q_oe ##1 q_oe;
	endproperty
	a_read_oe: assert property (p_read_oe)
		else $error("read burst not driven");
	property p_oe_cause;
		q_oe |-> $past(rd_start, 4) || $past(rd_start, 5);
	endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("output driven without read");
	property p_oe_drop;
		q_oe && $past(q_oe) && !$past(rd_start, 3) |=> !q_oe;
	endproperty
	a_oe_drop: assert property (p_oe_drop)
		else $error("output not released after burst");
	property p_write_pair;
		$rose(k) && !write_port_select_n |=>
			$rose(k_n) && write_port_select_n;
	endproperty
	a_write_pair: assert property (p_write_pair)
		else $error("second write word edge missing");
	property p_wsel_one;
		!write_port_select_n |-> $rose(k);
	endproperty
	a_wsel_one: assert property (p_wsel_one)
		else $error("write select off the input rise");
	property p_rsel_one;
		!read_port_select_n |-> $rose(k);
	endproperty
	a_rsel_one: assert property (p_rsel_one)
		else $error("read select off the input rise");
	property p_echo;
		echo_timing == $past(c);
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo clock does not follow output clock");
	property p_echo_n;
		echo_timing_n == $past(c_n);
	endproperty
	a_echo_n: assert property (p_echo_n)
		else $error("inverted echo clock wrong");
	c_read: cover property (rd_start);
	c_write: cover property ($rose(k) && !write_port_select_n);
	c_both: cover property (rd_start && !write_port_select_n);
endmodule

// [split_port_ddr_burst_sram_bench.sv]
`timescale 1ns/10ps
module split_port_ddr_burst_sram_bench import burst_sram_pkg::*;;
	typedef struct packed {
		logic [5:0] a;
		logic [17:0] w0;
		logic [17:0] w1;
		logic [3:0] ln;
		logic [1:0] op;
		logic [17:0] e0;
		logic [17:0] e1;
	} row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat_w = 32'h0;
	logic [31:0] dat_r;
	logic ack;
	logic single;
	logic locked;
	logic upd;
	logic [31:0] v;
	int n;
	int error_cnt = 0;
	int total_checks = 0;
	row_t rows [6] = '{
		'{6'h05, 18'h2aaaa, 18'h15555, 4'h0, 2'h1, 18'h2aaaa, 18'h15555},
		'{6'h05, 18'h00000, 18'h3ffff, 4'h6, 2'h1, 18'h2aa00, 18'h3ff55},
		'{6'h05, 18'h11111, 18'h11111, 4'hf, 2'h1, 18'h2aa00, 18'h3ff55},
		'{6'h3f, 18'h12345, 18'h0abcd, 4'h0, 2'h1, 18'h12345, 18'h0abcd},
		'{6'h3f, 18'h00000, 18'h3ffff, 4'h9, 2'h1, 18'h00145, 18'h0abff},
		'{6'h05, 18'h0f0f0, 18'h30f0f, 4'h0, 2'h3, 18'h0f0f0, 18'h30f0f}
	};
	always #2 clk_i = ~clk_i;
	// ----------------------------------------
	// both ends and the link
	// ----------------------------------------
	burst_sram_if #(.ADDR_W(6)) sram_link ();
	burst_sram_device #(.ADDR_W(6))
		i_burst_sram_device (.clk_i(clk_i), .rst_i(rst_i),
		.link(sram_link), .single_clock_o(single),
		.dll_locked_o(locked), .impedance_update_o(upd));
	burst_sram_ctrl #(.ADDR_W(6)) i_burst_sram_ctrl (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r),
		.ack_o(ack), .link(sram_link));
	split_port_ddr_burst_sram_monitor #(.ADDR_W(6))
		i_mon (.clk_i(clk_i), .rst_i(rst_i),
		.k(sram_link.k), .k_n(sram_link.k_n), .c(sram_link.c),
		.c_n(sram_link.c_n), .addr(sram_link.addr),
		.read_port_select_n(sram_link.read_port_select_n),
		.write_port_select_n(sram_link.write_port_select_n),
		.byte_lane_select_n(sram_link.byte_lane_select_n),
		.d(sram_link.d), .q(sram_link.q), .q_oe(sram_link.q_oe),
		.echo_timing(sram_link.echo_timing),
		.echo_timing_n(sram_link.echo_timing_n),
		.loop_disable_n(sram_link.loop_disable_n));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task wb(input logic w, input logic [5:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= wd;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		chk("ack", 32'h1, 32'(ack));
		rd = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task wr(input logic [5:0] a, input logic [31:0] wd);
		logic [31:0] t;
		wb(1'b1, a, wd, t);
	endtask
	task cmd(input logic [1:0] c);
		logic [31:0] s;
		int k;
		wr(REG_CMD, {30'h0, c});
		k = 0;
		do begin
			wb(1'b0, REG_STATUS, 32'h0, s);
			k++;
		end while (s[STAT_BUSY_BIT] !== 1'b0 && k < 40);
		chk("busy", 32'h0, 32'(s[STAT_BUSY_BIT]));
	endtask
	task xfer(input row_t r);
		wr(REG_ADDR, {26'h0, r.a});
		wr(REG_WDATA0, {14'h0, r.w0});
		wr(REG_WDATA1, {14'h0, r.w1});
		wr(REG_LANES, {28'h0, r.ln});
		if (r.op == 2'h3) begin
			cmd(2'h3);
		end else begin
			cmd(2'h1);
			cmd(2'h2);
		end
		wb(1'b0, REG_RDATA0, 32'h0, v);
		chk("rdata0", {14'h0, r.e0}, {14'h0, v[17:0]});
		wb(1'b0, REG_RDATA1, 32'h0, v);
		chk("rdata1", {14'h0, r.e1}, {14'h0, v[17:0]});
	endtask
	task wait_flag(input int lim);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((locked !== 1'b1 || lim < 0) && n < lim);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(negedge clk_i);
		chk("q_oe", 32'h0, 32'(sram_link.q_oe));
		chk("rps", 32'h1, 32'(sram_link.read_port_select_n));
		chk("wps", 32'h1, 32'(sram_link.write_port_select_n));
		chk("single", 32'h0, 32'(single));
		wb(1'b0, REG_CTRL, 32'h0, v);
		chk("ctrl", {30'h0, CTRL_RESET}, v);
		wb(1'b0, REG_LANES, 32'h0, v);
		chk("lanes", LANES_RESET, v);
		wr(6'h3c, 32'hffffffff);
		wb(1'b0, 6'h3c, 32'h0, v);
		chk("unmapped", 32'h0, v);
		sel <= 4'h1;
		wr(REG_ADDR, 32'hffffffff);
		sel <= 4'hf;
		wb(1'b0, REG_ADDR, 32'h0, v);
		chk("sel", 32'h000000ff, v);
		$display("test reset done");
		wr(REG_CTRL, 32'h3);
		for (int i = 0; i < 6; i++) begin
			xfer(rows[i]);
		end
		$display("test rows done");
		wait_flag(3000);
		chk("locked", 32'h1, 32'(locked));
		wr(REG_CTRL, 32'h1);
		repeat (4) @(posedge clk_i);
		chk("bypass", 32'h0, 32'(locked));
		wr(REG_CTRL, 32'h2);
		repeat (12) @(posedge clk_i);
		wr(REG_CTRL, 32'h3);
		wait_flag(3000);
		chk("relock", 32'h1, 32'(n >= 2040 && n <= 2060));
		wr(REG_CTRL, 32'h2);
		repeat (16) @(posedge clk_i);
		chk("stop_reset", 32'h0, 32'(locked));
		$display("test loop done");
		n = 0;
		while (upd !== 1'b1 && n < 1100) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (upd !== 1'b1 && n < 1100);
		chk("update_period", 32'd1024, 32'(n));
		$display("test impedance done");
		test_done;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		chk("watchdog", 32'h0, 32'h1);
		test_done;
	end
endmodule
